// ### rtl/fcd_pkg.sv
// Shared constants and types for the parallel flash command controller.
package fcd_pkg;

	////////////////////////////////////////////////////////////////////////
	// Clock and bus timing, in nanoseconds and in derived clock counts.
	localparam int CLK_NS   = 50;   // 20 MHz system clock period.
	localparam int T_WP_NS  = 70;   // Least write strobe low time.
	localparam int T_WPH_NS = 30;   // Least write strobe high time.
	localparam int T_AA_NS  = 115;  // Longest address to output delay.
	localparam int SYNC_CYC = 3;    // Depth of the data input synchroniser.
	localparam logic [2:0] WP_CYC  = 3'((T_WP_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [2:0] WPH_CYC = 3'((T_WPH_NS + CLK_NS - 1) / CLK_NS);
	// One extra cycle covers the agreement stage after the synchroniser.
	localparam logic [2:0] RD_CYC  =
		3'((T_AA_NS + CLK_NS - 1) / CLK_NS + SYNC_CYC + 1);

	////////////////////////////////////////////////////////////////////////
	// Widths and bus-cycle command codes.
	localparam int ADDR_W = 24;     // Flash address width.
	localparam int DATA_W = 16;     // Flash data width.
	localparam logic [7:0] CMD_ARRAY   = 8'hFF;
	localparam logic [7:0] CMD_IDENT   = 8'h90;
	localparam logic [7:0] CMD_QUERY   = 8'h98;
	localparam logic [7:0] CMD_STATUS  = 8'h70;
	localparam logic [7:0] CMD_CLR     = 8'h50;
	localparam logic [7:0] CMD_BUF     = 8'hE8;
	localparam logic [7:0] CMD_PROG    = 8'h40;
	localparam logic [7:0] CMD_ERASE   = 8'h20;
	localparam logic [7:0] CMD_SUSPEND = 8'hB0;
	localparam logic [7:0] CMD_CONFIRM = 8'hD0;
	localparam logic [7:0] CMD_CONFIG  = 8'hB8;
	localparam logic [7:0] CMD_LOCK    = 8'h60;
	localparam logic [7:0] CMD_LOCKSET = 8'h01;
	localparam logic [7:0] CMD_PROTECT = 8'hC0;

	////////////////////////////////////////////////////////////////////////
	// Buffered program count limits and status bit positions.
	localparam logic [5:0] BUF_MAX_BYTE = 6'h1F;
	localparam logic [5:0] BUF_MAX_WORD = 6'h0F;
	localparam int READY_BIT = 7;   // Ready bit of status and buffer status.

	////////////////////////////////////////////////////////////////////////
	// User operations, read modes, step kinds and controller states.
	typedef enum logic [3:0] {
		OP_READ, OP_ARRAY, OP_IDENT, OP_QUERY, OP_STATUS, OP_CLR,
		OP_PROG, OP_BUF, OP_BUFW, OP_ERASE, OP_SUSPEND, OP_RESUME,
		OP_CONFIG, OP_LOCKSET, OP_LOCKCLR, OP_PROTECT
	} fcd_op_t;
	typedef enum logic [1:0] {
		MODE_ARRAY, MODE_IDENT, MODE_QUERY, MODE_STATUS
	} fcd_mode_t;
	typedef enum logic [1:0] {K_WR, K_RD, K_END} fcd_kind_t;
	typedef enum logic [2:0] {
		ST_IDLE, ST_NEXT, ST_WLOW, ST_WHIGH, ST_RLOW, ST_RHIGH
	} fcd_state_t;

endpackage

// ### rtl/fcd_host.sv
// Host-side controller that issues flash command sequences on the pins.
//
// Contract
// - 90h write selects identifier reads.
// - 98h write selects query table reads.
// - 70h write makes next read return status.
// - 50h write clears the status register.
// - Buffer program: E8h then count, same block.
// - Check buffer status ready before continuing.
// - Count plus one data writes follow count.
// - D0h confirms buffer; anything else aborts.
// - 40h or 10h setup, then address and data.
// - Erase is 20h then D0h in block.
// - Configuration is B8h then configuration code.
// - 60h then 01h sets block lock.
// - 60h then D0h starts lock clearing.
// - C0h then address and data programs protection.
`timescale 1ns/1ps
`default_nettype none

module fcd_host (
	// Clock and reset.
	input  wire  logic                       clk,
	input  wire  logic                       rst_n,
	// User command port.
	input  wire  logic                       cmd_valid,
	input  wire  fcd_pkg::fcd_op_t           cmd_op,
	input  wire  logic [fcd_pkg::ADDR_W-1:0] cmd_addr,
	input  wire  logic [fcd_pkg::DATA_W-1:0] cmd_data,
	input  wire  logic                       byte_mode,
	output logic                             cmd_ready,
	output logic                             done,
	output logic                             err,
	output logic [fcd_pkg::DATA_W-1:0]       rd_data,
	output fcd_pkg::fcd_mode_t               read_mode,
	// Flash pins.
	output logic [fcd_pkg::ADDR_W-1:0]       f_addr,
	output logic [fcd_pkg::DATA_W-1:0]       f_dq_o,
	output logic                             f_dq_oe,
	input  wire  logic [fcd_pkg::DATA_W-1:0] f_dq_i,
	output logic                             f_ce_n,
	output logic                             f_oe_n,
	output logic                             f_we_n
);

	////////////////////////////////////////////////////////////////////////
	// Step decoding shared by the sequencer and the read mode register.

	// Kind of bus cycle an operation needs at a given step.
	function automatic fcd_pkg::fcd_kind_t step_kind(
		input fcd_pkg::fcd_op_t op, input logic [1:0] st, input logic last);
		step_kind = fcd_pkg::K_END;
		unique case (op)
			fcd_pkg::OP_READ: begin
				if (st == 2'd0) step_kind = fcd_pkg::K_RD;
			end
			fcd_pkg::OP_BUF: begin
				// The second step polls buffer availability.
				if (st == 2'd1) step_kind = fcd_pkg::K_RD;
				else if (st != 2'd3) step_kind = fcd_pkg::K_WR;
			end
			fcd_pkg::OP_BUFW: begin
				// The confirm follows only after the last data word.
				if (st == 2'd0 || (st == 2'd1 && last)) step_kind = fcd_pkg::K_WR;
			end
			fcd_pkg::OP_PROG, fcd_pkg::OP_ERASE, fcd_pkg::OP_CONFIG,
			fcd_pkg::OP_LOCKSET, fcd_pkg::OP_LOCKCLR, fcd_pkg::OP_PROTECT: begin
				if (st < 2'd2) step_kind = fcd_pkg::K_WR;
			end
			default: begin
				if (st == 2'd0) step_kind = fcd_pkg::K_WR;
			end
		endcase
	endfunction

	// Data driven on a write step; user data fills argument cycles.
	function automatic logic [15:0] step_data(
		input fcd_pkg::fcd_op_t op, input logic [1:0] st, input logic [15:0] d);
		logic [7:0] c;
		c = 8'h00;
		step_data = 16'h0000;
		unique case (op)
			fcd_pkg::OP_ARRAY: c = fcd_pkg::CMD_ARRAY;
			fcd_pkg::OP_IDENT: c = fcd_pkg::CMD_IDENT;
			fcd_pkg::OP_QUERY: c = fcd_pkg::CMD_QUERY;
			fcd_pkg::OP_STATUS: c = fcd_pkg::CMD_STATUS;
			fcd_pkg::OP_CLR: c = fcd_pkg::CMD_CLR;
			fcd_pkg::OP_SUSPEND: c = fcd_pkg::CMD_SUSPEND;
			fcd_pkg::OP_RESUME: c = fcd_pkg::CMD_CONFIRM;
			fcd_pkg::OP_BUF: c = (st == 2'd0) ? fcd_pkg::CMD_BUF : 8'h00;
			fcd_pkg::OP_BUFW: c = (st == 2'd1) ? fcd_pkg::CMD_CONFIRM : 8'h00;
			fcd_pkg::OP_PROG: c = (st == 2'd0) ? fcd_pkg::CMD_PROG : 8'h00;
			fcd_pkg::OP_ERASE: c = (st == 2'd0) ? fcd_pkg::CMD_ERASE
				: fcd_pkg::CMD_CONFIRM;
			fcd_pkg::OP_CONFIG: c = (st == 2'd0) ? fcd_pkg::CMD_CONFIG : 8'h00;
			fcd_pkg::OP_LOCKSET: c = (st == 2'd0) ? fcd_pkg::CMD_LOCK
				: fcd_pkg::CMD_LOCKSET;
			fcd_pkg::OP_LOCKCLR: c = (st == 2'd0) ? fcd_pkg::CMD_LOCK
				: fcd_pkg::CMD_CONFIRM;
			fcd_pkg::OP_PROTECT: c = (st == 2'd0) ? fcd_pkg::CMD_PROTECT : 8'h00;
			fcd_pkg::OP_READ: c = 8'h00;
		endcase
		step_data = {8'h00, c};
		// Argument cycles carry the user's word unchanged.
		if ((op == fcd_pkg::OP_BUFW && st == 2'd0) || (st == 2'd2 && op == fcd_pkg::OP_BUF)
			|| (st == 2'd1 && (op == fcd_pkg::OP_PROG || op == fcd_pkg::OP_CONFIG
			|| op == fcd_pkg::OP_PROTECT))) begin
			step_data = d;
		end
	endfunction

	////////////////////////////////////////////////////////////////////////
	// State and registered outputs.
	fcd_pkg::fcd_state_t          state_r;    // Sequencer state.
	fcd_pkg::fcd_op_t             op_r;       // Operation in progress.
	fcd_pkg::fcd_mode_t           mode_r;     // Read mode last selected.
	logic [1:0]                   step_r;     // Step within the sequence.
	logic [2:0]                   cnt_r;      // Strobe timing counter.
	logic [5:0]                   left_r;     // Buffer words still owed.
	logic [fcd_pkg::ADDR_W-1:0]   addr_r;     // Latched user address.
	logic [fcd_pkg::ADDR_W-1:0]   base_r;     // Block address of buffer.
	logic [fcd_pkg::DATA_W-1:0]   data_r;     // Latched user data.
	logic [fcd_pkg::DATA_W-1:0]   rd_r;       // Last captured read word.
	logic                         ready_r;    // Command port is free.
	logic                         done_r;     // Completion pulse.
	logic                         err_r;      // Refusal pulse.
	logic [fcd_pkg::ADDR_W-1:0]   f_addr_r;   // Address pins.
	logic [fcd_pkg::DATA_W-1:0]   f_dq_o_r;   // Data pins driven.
	logic                         f_dq_oe_r;  // Data pin enable.
	logic                         f_ce_n_r;   // Chip enable, low active.
	logic                         f_oe_n_r;   // Output enable, low active.
	logic                         f_we_n_r;   // Write strobe, low active.

	////////////////////////////////////////////////////////////////////////
	// Data input synchroniser; a bit changes once stages two and three agree.
	logic [fcd_pkg::DATA_W-1:0] s1_r;
	logic [fcd_pkg::DATA_W-1:0] s2_r;
	logic [fcd_pkg::DATA_W-1:0] s3_r;
	logic [fcd_pkg::DATA_W-1:0] acc_r;

	// The three stages shift the raw pins on every edge.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s1_r <= 16'h0000;
			s2_r <= 16'h0000;
			s3_r <= 16'h0000;
		end else begin
			s1_r <= f_dq_i;
			s2_r <= s1_r;
			s3_r <= s2_r;
		end
	end

	// Each bit accepts a change only when the late stages agree.
	genvar gi;
	generate
		for (gi = 0; gi < fcd_pkg::DATA_W; gi++) begin : g_agree
			always_ff @(posedge clk or negedge rst_n) begin
				if (!rst_n) acc_r[gi] <= 1'b0;
				else if (s2_r[gi] == s3_r[gi]) acc_r[gi] <= s3_r[gi];
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// Decoding of the current step.
	wire fcd_pkg::fcd_kind_t kind_w  = step_kind(op_r, step_r, left_r == 6'h00);
	wire logic [15:0]        wdat_w  = step_data(op_r, step_r, data_r);
	// The confirm of a buffer goes to the block that the setup named.
	wire logic [23:0]        wadr_w  = (op_r == fcd_pkg::OP_BUFW) && (step_r == 2'd1)
		? base_r : addr_r;
	wire logic [5:0]         cmax_w  = byte_mode ? fcd_pkg::BUF_MAX_BYTE
		: fcd_pkg::BUF_MAX_WORD;
	// counts outside the mode's range are refused.
	wire logic               bad_cnt = (cmd_data[15:6] != 10'h000) || (cmd_data[5:0] > cmax_w);
	wire logic               refuse  = (cmd_op == fcd_pkg::OP_BUFW && left_r == 6'h00)
		|| (cmd_op == fcd_pkg::OP_BUF && bad_cnt);
	wire logic               wp_end  = cnt_r == fcd_pkg::WP_CYC - 3'd1;
	wire logic               wph_end = cnt_r == fcd_pkg::WPH_CYC - 3'd1;
	wire logic               rd_end  = cnt_r == fcd_pkg::RD_CYC - 3'd1;
	// a busy status word carries only bit 7, so the rest is hidden.
	wire logic               busy_w  = (mode_r == fcd_pkg::MODE_STATUS)
		&& (op_r == fcd_pkg::OP_READ) && !acc_r[fcd_pkg::READY_BIT];
	wire logic [15:0]        rmask_w = busy_w ? 16'h0000 : acc_r;
	// the buffer is polled again until its ready bit is set.
	wire logic               retry_w = (op_r == fcd_pkg::OP_BUF)
		&& !rd_r[fcd_pkg::READY_BIT];
	wire logic [1:0]         step_w  = retry_w ? 2'd0 : step_r + 2'd1;

	////////////////////////////////////////////////////////////////////////
	// Sequencer: one bus cycle per step, strobes timed by the counter.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_r <= fcd_pkg::ST_IDLE;
			op_r <= fcd_pkg::OP_READ;
			step_r <= 2'd0;
			cnt_r <= 3'd0;
			addr_r <= 24'h000000;
			data_r <= 16'h0000;
			rd_r <= 16'h0000;
			ready_r <= 1'b0;
			done_r <= 1'b0;
			err_r <= 1'b0;
			f_addr_r <= 24'h000000;
			f_dq_o_r <= 16'h0000;
			f_dq_oe_r <= 1'b0;
			f_ce_n_r <= 1'b1;
			f_oe_n_r <= 1'b1;
			f_we_n_r <= 1'b1;
		end else begin
			done_r <= 1'b0;
			err_r <= 1'b0;
			cnt_r <= cnt_r + 3'd1;
			unique case (state_r)
				fcd_pkg::ST_IDLE: begin
					ready_r <= 1'b1;
					// Refused commands never touch the pins.
					if (cmd_valid && ready_r && refuse) begin
						err_r <= 1'b1;
						done_r <= 1'b1;
					end else if (cmd_valid && ready_r) begin
						ready_r <= 1'b0;
						op_r <= cmd_op;
						addr_r <= cmd_addr;
						data_r <= cmd_data;
						step_r <= 2'd0;
						state_r <= fcd_pkg::ST_NEXT;
					end
				end
				fcd_pkg::ST_NEXT: begin
					cnt_r <= 3'd0;
					f_addr_r <= wadr_w;
					unique case (kind_w)
						fcd_pkg::K_WR: begin
							// Address and data go out with the strobe edge.
							f_dq_o_r <= wdat_w;
							f_dq_oe_r <= 1'b1;
							f_ce_n_r <= 1'b0;
							f_we_n_r <= 1'b0;
							state_r <= fcd_pkg::ST_WLOW;
						end
						fcd_pkg::K_RD: begin
							f_ce_n_r <= 1'b0;
							f_oe_n_r <= 1'b0;
							state_r <= fcd_pkg::ST_RLOW;
						end
						fcd_pkg::K_END: begin
							done_r <= 1'b1;
							ready_r <= 1'b1;
							state_r <= fcd_pkg::ST_IDLE;
						end
					endcase
				end
				fcd_pkg::ST_WLOW: begin
					// The device latches address and data on this rising edge.
					if (wp_end) begin
						f_we_n_r <= 1'b1;
						cnt_r <= 3'd0;
						state_r <= fcd_pkg::ST_WHIGH;
					end
				end
				fcd_pkg::ST_WHIGH: begin
					// Strobe high time also covers recovery before a read.
					if (wph_end) begin
						f_dq_oe_r <= 1'b0;
						f_ce_n_r <= 1'b1;
						step_r <= step_r + 2'd1;
						state_r <= fcd_pkg::ST_NEXT;
					end
				end
				fcd_pkg::ST_RLOW: begin
					// The wait spans access time plus the synchroniser.
					if (rd_end) begin
						rd_r <= rmask_w;
						f_ce_n_r <= 1'b1;
						f_oe_n_r <= 1'b1;
						state_r <= fcd_pkg::ST_RHIGH;
					end
				end
				fcd_pkg::ST_RHIGH: begin
					// One cycle lets the device release the data pins.
					step_r <= step_w;
					state_r <= fcd_pkg::ST_NEXT;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Buffer bookkeeping: owed words, block address, abort on other work.
	wire logic wr_done = (state_r == fcd_pkg::ST_WHIGH) && wph_end;
	wire logic start_w = (state_r == fcd_pkg::ST_IDLE) && cmd_valid && ready_r && !refuse;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			left_r <= 6'h00;
			base_r <= 24'h000000;
		end else if (start_w && cmd_op != fcd_pkg::OP_BUFW && cmd_op != fcd_pkg::OP_READ) begin
			// any other command except a read aborts the buffer.
			left_r <= 6'h00;
			if (cmd_op == fcd_pkg::OP_BUF) base_r <= cmd_addr;
		end else if (wr_done && op_r == fcd_pkg::OP_BUF && step_r == 2'd2) begin
			// count plus one data words are owed.
			left_r <= data_r[5:0] + 6'd1;
		end else if (wr_done && op_r == fcd_pkg::OP_BUFW && step_r == 2'd0) begin
			left_r <= left_r - 6'd1;
		end
	end

	// Read mode follows mode-select commands once they complete.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) mode_r <= fcd_pkg::MODE_ARRAY;
		else if (state_r == fcd_pkg::ST_NEXT && kind_w == fcd_pkg::K_END) begin
			if (op_r == fcd_pkg::OP_ARRAY) mode_r <= fcd_pkg::MODE_ARRAY;
			if (op_r == fcd_pkg::OP_IDENT) mode_r <= fcd_pkg::MODE_IDENT;
			if (op_r == fcd_pkg::OP_QUERY) mode_r <= fcd_pkg::MODE_QUERY;
			if (op_r == fcd_pkg::OP_STATUS) mode_r <= fcd_pkg::MODE_STATUS;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Output wiring, all straight from flip-flops.
	assign cmd_ready = ready_r;
	assign done      = done_r;
	assign err       = err_r;
	assign rd_data   = rd_r;
	assign read_mode = mode_r;
	assign f_addr    = f_addr_r;
	assign f_dq_o    = f_dq_o_r;
	assign f_dq_oe   = f_dq_oe_r;
	assign f_ce_n    = f_ce_n_r;
	assign f_oe_n    = f_oe_n_r;
	assign f_we_n    = f_we_n_r;

	////////////////////////////////////////////////////////////////////////
	// Checks and coverage.
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	wire logic wlow = state_r == fcd_pkg::ST_WLOW;

	chk_array_code: assert property (
		(wlow && op_r == fcd_pkg::OP_ARRAY) |-> f_dq_o_r[7:0] == 8'hFF)
		else $error("array select code wrong");
	chk_ident_mode: assert property (
		(done_r && op_r == fcd_pkg::OP_IDENT && !err_r) |-> mode_r == fcd_pkg::MODE_IDENT)
		else $error("identifier mode not taken");
	chk_query_mode: assert property (
		(wlow && op_r == fcd_pkg::OP_QUERY) |-> ##[1:8] mode_r == fcd_pkg::MODE_QUERY)
		else $error("query mode not taken");
	chk_status_code: assert property (
		(wlow && op_r == fcd_pkg::OP_STATUS) |-> f_dq_o_r[7:0] == 8'h70 && f_dq_oe_r)
		else $error("status select code wrong");
	chk_busy_mask: assert property (
		(done_r && op_r == fcd_pkg::OP_READ && mode_r == fcd_pkg::MODE_STATUS
		&& !rd_r[7]) |-> rd_r == 16'h0000)
		else $error("busy status bits leaked");
	chk_buf_poll: assert property (
		(state_r == fcd_pkg::ST_RHIGH && op_r == fcd_pkg::OP_BUF && !rd_r[7])
		|=> step_r == 2'd0 ##1 (wlow && f_dq_o_r[7:0] == 8'hE8))
		else $error("buffer not polled again");
	chk_buf_load: assert property (
		(wr_done && op_r == fcd_pkg::OP_BUF && step_r == 2'd2)
		|=> left_r == $past(data_r[5:0]) + 6'd1)
		else $error("buffer count not loaded");
	chk_buf_confirm: assert property (
		(op_r == fcd_pkg::OP_BUFW && $changed(left_r) && left_r == 6'h00)
		|-> ##[1:6] (wlow && f_dq_o_r[7:0] == 8'hD0))
		else $error("buffer confirm missing");
	chk_erase_pair: assert property (
		(wlow && op_r == fcd_pkg::OP_ERASE && step_r == 2'd1) |-> f_dq_o_r[7:0] == 8'hD0
		&& $past(f_dq_o_r, 3) == 16'h0020)
		else $error("erase confirm wrong");
	chk_we_width: assert property (
		$fell(f_we_n_r) |-> !f_we_n_r ##1 !f_we_n_r ##1 f_we_n_r)
		else $error("write strobe width wrong");

	cov_buf_prog: cover property (done_r && op_r == fcd_pkg::OP_BUFW && left_r == 6'h00);
	cov_status_busy: cover property (done_r && busy_w);
	cov_refused: cover property (err_r);

endmodule

`default_nettype wire

// ### bench/fcd_flash_model.sv
// Behavioural flash device that answers the controller's pin cycles.
`timescale 1ns/1ps
`default_nettype none
module fcd_flash_model #(
	parameter logic [15:0] MAKER_ID = 16'h00A7, // Arbitrary value.
	parameter logic [15:0] PART_ID  = 16'h0B3C  // Arbitrary value.
) (
	// Flash pins as the device sees them.
	input  wire logic [23:0] f_addr,
	input  wire logic [15:0] f_dq_o,
	input  wire logic        f_dq_oe,
	input  wire logic        f_ce_n,
	input  wire logic        f_oe_n,
	input  wire logic        f_we_n,
	output logic [15:0]      f_dq_i
);
	fcd_pkg::fcd_mode_t mode = fcd_pkg::MODE_ARRAY; // Current read mode.
	logic [15:0] wd[$];            // Data of every write cycle.
	logic [23:0] wa[$];            // Address of every write cycle.
	int          polls = 0;        // Buffer polls still answered not ready.
	int          arg   = 0;        // Argument writes still owed.
	logic        cnt   = 1'b0;     // Next write is a buffer count.
	logic        extended_status_reg   = 1'b0;     // Reads return buffer status.
	logic        busy  = 1'b0;     // Write state machine busy, set by bench.
	logic [15:0] last  = 16'h0000; // Last value driven on the data bus.
	logic [15:0] v;                // Word being driven.
	logic [7:0]  setup = 8'h00;    // Setup code whose argument comes next.
	bit          lk[int];          // Lock bits, keyed by block index.
	bit          started = 1'b0;   // Some program has been started.
	int          refused = 0;      // Erase or program refused by a lock.
	int          susp    = 0;      // Suspends taken after a program started.
	// Lowest address bit of the block index; a plain default.
	localparam int BLK_LSB = 17;
	wire         rd_en = !f_ce_n && !f_oe_n;
	initial f_dq_i = 16'h0000;
	////////////////////////////////////////////////////////////////////////
	// Writes are taken at the rising strobe; arguments never decode as codes.
	always @(posedge f_we_n) begin
		if (!f_ce_n && f_dq_oe) begin
			wd.push_back(f_dq_o);
			wa.push_back(f_addr);
			extended_status_reg = (cnt && f_dq_o[7:0] == 8'hE8);
			if (cnt && !extended_status_reg) begin
				cnt = 1'b0;
				arg = f_dq_o[5:0] + 2;
			end else if (cnt) begin
				cnt = 1'b1;
			end else if (arg > 0) begin
				arg--;
				if (setup == 8'h60 && f_dq_o[7:0] == 8'hD0) lk.delete();
				else if (setup == 8'h60) lk[int'(f_addr >> BLK_LSB)] = 1'b1;
				else if (arg == 0 && setup inside {8'h20, 8'h40, 8'h10, 8'hE8}
					&& lk.exists(int'(f_addr >> BLK_LSB))) refused++;
				else if (arg == 0 && setup inside {8'h40, 8'h10, 8'hE8}) started = 1'b1;
			end else begin
				case (f_dq_o[7:0])
					8'hFF: mode = fcd_pkg::MODE_ARRAY;
					8'h90: mode = fcd_pkg::MODE_IDENT;
					8'h98: mode = fcd_pkg::MODE_QUERY;
					8'h70: mode = fcd_pkg::MODE_STATUS;
					8'hE8: begin
						extended_status_reg = 1'b1;
						cnt = 1'b1;
						setup = 8'hE8;
					end
					8'h40, 8'h10, 8'hC0, 8'hB8, 8'h60, 8'h20: begin
						arg = 1;
						setup = f_dq_o[7:0];
					end
					8'hB0: if (started) susp++;
					default: ;
				endcase
			end
		end
	end
	// Each buffer poll that ends uses up one not-ready answer.
	always @(posedge f_oe_n) if (extended_status_reg && polls > 0) polls--;
	////////////////////////////////////////////////////////////////////////
	// read answers
	always @(rd_en or f_addr or mode) begin
		if (rd_en) begin
			if (extended_status_reg) v = (polls > 0) ? 16'h0000 : 16'h0080;
			else if (mode == fcd_pkg::MODE_IDENT) v = f_addr[0] ? PART_ID : MAKER_ID;
			else if (mode == fcd_pkg::MODE_QUERY) v = 16'h0051 + f_addr[15:0];
			else if (mode == fcd_pkg::MODE_STATUS) v = busy ? ~last & 16'hFF7F : 16'h0080;
			else v = f_addr[15:0] ^ 16'h5A5A;
			f_dq_i <= #20 v;
			last = v;
		end else begin
			// A released bus must not keep the last word alive.
			f_dq_i <= #10 ~last;
		end
	end
endmodule
`default_nettype wire

// ### bench/flash_command_decoder_test.sv
// Self-checking bench for the flash command controller.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin fails++; \
	$display("MISMATCH t=%0t got %h exp %h", $time, (a), (b)); end end
module flash_command_decoder_test;
	logic               clk = 1'b0, rst_n = 1'b0, cmd_valid = 1'b0, byte_mode = 1'b0;
	fcd_pkg::fcd_op_t   cmd_op = fcd_pkg::OP_READ;
	logic [23:0]        cmd_addr = 24'h000000, f_addr, ba;
	logic [15:0]        cmd_data = 16'h0000, f_dq_o, f_dq_i, rd_data;
	logic               cmd_ready, done, err, f_dq_oe, f_ce_n, f_oe_n, f_we_n;
	fcd_pkg::fcd_mode_t read_mode;
	logic [41:0]        ex[$]; // Expected writes: addr check, full width, address, data.
	int                 fails = 0, cmp_count = 0, seed = 11, owe = 0, n, k;
	fcd_host uut (.clk, .rst_n, .cmd_valid, .cmd_op, .cmd_addr, .cmd_data, .byte_mode,
		.cmd_ready, .done, .err, .rd_data, .read_mode, .f_addr, .f_dq_o, .f_dq_oe,
		.f_dq_i, .f_ce_n, .f_oe_n, .f_we_n);
	fcd_flash_model fm (.f_addr, .f_dq_o, .f_dq_oe, .f_ce_n, .f_oe_n, .f_we_n, .f_dq_i);
	initial forever #25 clk = ~clk;
	////////////////////////////////////////////////////////////////////////
	// Adds one write that the pins must show.
	task automatic ex1(bit af, bit ff, logic [23:0] a, logic [15:0] d);
		ex.push_back({af, ff, a, d});
	endtask
	// Issues one command, waits for done and checks the writes seen by the device.
	task automatic run(fcd_pkg::fcd_op_t op, logic [23:0] a, logic [15:0] d, bit xe);
		int c, k0;
		logic [41:0] w;
		c = 0;
		k0 = fm.wd.size();
		ex.delete();
		if (!xe && op != fcd_pkg::OP_READ && op != fcd_pkg::OP_BUFW) owe = 0;
		if (!xe) case (op)
			fcd_pkg::OP_ARRAY:   ex1(0, 0, a, 16'h00FF);
			fcd_pkg::OP_IDENT:   ex1(0, 0, a, 16'h0090);
			fcd_pkg::OP_QUERY:   ex1(0, 0, a, 16'h0098);
			fcd_pkg::OP_STATUS:  ex1(0, 0, a, 16'h0070);
			fcd_pkg::OP_CLR:     ex1(0, 0, a, 16'h0050);
			fcd_pkg::OP_SUSPEND: ex1(0, 0, a, 16'h00B0);
			fcd_pkg::OP_RESUME:  ex1(0, 0, a, 16'h00D0);
			fcd_pkg::OP_PROG: begin ex1(0, 0, a, 16'h0040); ex1(1, 1, a, d); end
			fcd_pkg::OP_CONFIG: begin ex1(0, 0, a, 16'h00B8); ex1(0, 1, a, d); end
			fcd_pkg::OP_PROTECT: begin ex1(0, 0, a, 16'h00C0); ex1(1, 1, a, d); end
			fcd_pkg::OP_ERASE: begin ex1(1, 0, a, 16'h0020); ex1(1, 0, a, 16'h00D0); end
			fcd_pkg::OP_LOCKSET: begin ex1(0, 0, a, 16'h0060); ex1(1, 0, a, 16'h0001); end
			fcd_pkg::OP_LOCKCLR: begin ex1(0, 0, a, 16'h0060); ex1(0, 0, a, 16'h00D0); end
			fcd_pkg::OP_BUF: begin
				repeat (fm.polls + 1) ex1(1, 0, a, 16'h00E8);
				ex1(1, 1, a, d);
				ba = a;
				owe = d[5:0] + 1;
			end
			fcd_pkg::OP_BUFW: begin
				ex1(1, 1, a, d);
				owe--;
				if (owe == 0) ex1(1, 0, ba, 16'h00D0);
			end
			default: ;
		endcase
		cmd_op = op;
		cmd_addr = a;
		cmd_data = d;
		cmd_valid = 1'b1;
		while (cmd_ready !== 1'b1 && c < 50) begin @(posedge clk); #1 c++; end
		@(posedge clk);
		#1 cmd_valid = 1'b0;
		c = 0;
		while (done !== 1'b1 && c < 400) begin @(posedge clk); #1 c++; end
		`CHK(done, 1'b1)
		`CHK(err, xe)
		`CHK(fm.wd.size() - k0, ex.size())
		for (int i = 0; i < ex.size(); i++) begin
			w = ex[i];
			`CHK(fm.wd[k0+i] & (w[40] ? 16'hFFFF : 16'h00FF), w[15:0])
			if (w[41]) `CHK(fm.wa[k0+i], w[39:16])
		end
	endtask
	// Reads one word in the current mode and compares it.
	task automatic rd(logic [23:0] a, logic [15:0] e);
		run(fcd_pkg::OP_READ, a, 16'h0000, 1'b0);
		`CHK(rd_data, e)
	endtask
	task automatic tally_and_finish;
		$display("comparisons %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////
	// A hang is cut short long after the sequence should have ended.
	initial begin
		#3000000;
		fails++;
		tally_and_finish();
	end
	initial begin
		repeat (5) @(posedge clk);
		`CHK(f_we_n, 1'b1)
		#1 rst_n = 1'b1;
		@(posedge clk);
		#1 `CHK(read_mode, fcd_pkg::MODE_ARRAY)
		// Every read mode, then reads that must follow it.
		run(fcd_pkg::OP_IDENT, 24'h000000, 16'h0000, 1'b0);
		`CHK(read_mode, fcd_pkg::MODE_IDENT)
		rd(24'h000000, 16'h00A7);
		rd(24'h000001, 16'h0B3C);
		run(fcd_pkg::OP_QUERY, 24'h000000, 16'h0000, 1'b0);
		rd(24'h000010, 16'h0061);
		run(fcd_pkg::OP_STATUS, 24'h000000, 16'h0000, 1'b0);
		`CHK(read_mode, fcd_pkg::MODE_STATUS)
		rd(24'($random(seed)), 16'h0080);
		fm.busy = 1'b1;
		rd(24'h000004, 16'h0000);
		fm.busy = 1'b0;
		run(fcd_pkg::OP_ARRAY, 24'h000000, 16'h0000, 1'b0);
		rd(24'h001234, 16'h486E);
		// Counts beyond the limit of each width, and data with nothing owed.
		run(fcd_pkg::OP_BUF, 24'h010000, 16'h0010, 1'b1);
		byte_mode = 1'b1;
		run(fcd_pkg::OP_BUF, 24'h010000, 16'h0020, 1'b1);
		run(fcd_pkg::OP_BUF, 24'h010000, 16'h0040, 1'b1);
		run(fcd_pkg::OP_BUFW, 24'h010000, 16'h0001, 1'b1);
		for (int i = 0; i < 4; i++) begin
			byte_mode = i[0];
			n = i[1] ? (i[0] ? 31 : 15) : $unsigned($random(seed)) % 4;
			fm.polls = i;
			run(fcd_pkg::OP_BUF, 24'(24'h020000 + i), 16'(n), 1'b0);
			repeat (n + 1) run(fcd_pkg::OP_BUFW, 24'(24'h020000 + i), 16'($random(seed)), 1'b0);
		end
		run(fcd_pkg::OP_BUF, 24'h030000, 16'h0000, 1'b0);
		run(fcd_pkg::OP_ERASE, 24'h030000, 16'h0000, 1'b0);
		run(fcd_pkg::OP_BUFW, 24'h030000, 16'h0005, 1'b1);
		// Random single and two-cycle commands.
		repeat (60) begin
			k = $unsigned($random(seed)) % 9;
			run(fcd_pkg::fcd_op_t'(k < 2 ? k + 5 : k + 7), 24'($random(seed)),
				16'($random(seed)), 1'b0);
		end
		// Locks refuse erase until a clear; suspend after a program start.
		run(fcd_pkg::OP_LOCKCLR, 24'h000000, 16'h0000, 1'b0);
		k = fm.refused;
		run(fcd_pkg::OP_LOCKSET, 24'h040000, 16'h0000, 1'b0);
		run(fcd_pkg::OP_ERASE, 24'h040010, 16'h0000, 1'b0);
		run(fcd_pkg::OP_ERASE, 24'h060000, 16'h0000, 1'b0);
		`CHK(fm.refused - k, 1)
		run(fcd_pkg::OP_LOCKCLR, 24'h000000, 16'h0000, 1'b0);
		run(fcd_pkg::OP_ERASE, 24'h040000, 16'h0000, 1'b0);
		`CHK(fm.refused - k, 1)
		k = fm.susp;
		run(fcd_pkg::OP_PROG, 24'h060000, 16'h1234, 1'b0);
		run(fcd_pkg::OP_SUSPEND, 24'h000000, 16'h0000, 1'b0);
		`CHK(fm.susp - k, 1)
		tally_and_finish();
	end
endmodule
`default_nettype wire
